/* lss_ctrl_model.sv */
// Higher-level safety controller model driving both select paths
module lss_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic want_sel,
    input wire logic via_bus,
    output logic failsafe_input,
    output logic fieldbus_select
);
    timeunit 1ns;
    timeprecision 100ps;
    // Registered outputs, as a real controller stage would give
    // one source selects, release deselects
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            failsafe_input <= 1'b0;
            fieldbus_select <= 1'b0;
        end else begin
            failsafe_input <= want_sel & ~via_bus;
            fieldbus_select <= want_sel & via_bus;
        end
    end
endmodule : lss_ctrl_model

/* lss_delay_timer.sv */
// Tick-based one-shot delay timer
module lss_delay_timer
    import lss_pkg::*;
#(
    parameter int W = LSS_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic [W-1:0] load,
    output logic done
);
    // Elaboration check: a one-bit count cannot hold a useful delay
    if (W < 2) begin : g_bad_width
        $error("lss_delay_timer: W too small");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
        logic done;
    } lss_tmr_s;

    lss_tmr_s q, next_q;

    // Abort wins; a zero load expires on the next cycle
    always_comb begin
        next_q = q;
        if (abort) begin
            next_q.run = 1'b0;
            next_q.done = 1'b0;
        end else if (start) begin
            next_q.cnt = load;
            next_q.run = 1'b1;
            next_q.done = 1'b0;
        end else if (q.run && q.cnt == '0) begin
            next_q.run = 1'b0;
            next_q.done = 1'b1;
        end else if (q.run && tick) begin
            next_q.cnt = q.cnt - W'(1);
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign done = q.done;
endmodule : lss_delay_timer

/* lss_limited_speed_select.sv */
// Limited-speed function select/deselect sequencer with APB registers
module lss_limited_speed_select
    import lss_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic failsafe_input,
    input wire logic fieldbus_select,
    input wire logic run_command,
    input wire logic [LSS_W-1:0] load_speed,
    input wire logic [LSS_W-1:0] speed_setpoint,
    output logic [LSS_W-1:0] setpoint_out,
    output logic quick_stop_command,
    output logic run_enable,
    output logic limited_speed_active,
    output logic irq
);
    // Elaboration check: the divider needs at least one cycle per tick
    if (TICK_DIV < 1) begin : g_bad_div
        $error("lss_limited_speed_select: TICK_DIV must be >= 1");
    end

    typedef struct packed {
        lss_state_e st;
        logic ramp_sup;
        logic [LSS_W-1:0] limit;
        logic [LSS_W-1:0] margin;
        logic [LSS_W-1:0] brake_dly;
        logic [LSS_W-1:0] mon_dly;
        logic [LSS_W-1:0] step;
        logic [EV_N-1:0] irq_stat;
        logic [EV_N-1:0] irq_en;
        logic [31:0] prdata;
        logic [LSS_W-1:0] setpoint;
        logic quick_stop;
        logic run_en;
        logic active;
        logic [31:0] div;
        logic tick;
    } lss_main_s;

    lss_main_s q, next_q;
    logic sel_any;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [LSS_W-1:0] clamp_val;
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr;
    logic start_brake;
    logic start_mon;
    logic start_ramp;
    logic brake_done;
    logic mon_done;
    logic ramp_reached;
    logic ramp_slow;

    assign sel_any = failsafe_input | fieldbus_select;
    // Saturate so a margin above the limit clamps to standstill
    assign clamp_val = (q.limit > q.margin) ? q.limit - q.margin : '0;

    // Zero-wait APB slave
    assign pready = 1'b1;
    assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_LIMIT) || (paddr == ADDR_MARGIN)
        || (paddr == ADDR_BRAKE_DLY) || (paddr == ADDR_MON_DLY) || (paddr == ADDR_STEP)
        || (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_EN)
        || (paddr == ADDR_IRQ_CLR);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign clr = (wr_en && paddr == ADDR_IRQ_CLR) ? pwdata[EV_N-1:0] : '0;

    // Timer starts come from the state transition taken this cycle
    assign start_brake = (q.st == LSS_IDLE) && sel_any && q.ramp_sup;
    assign start_mon = (q.st == LSS_IDLE) && sel_any && !q.ramp_sup;
    assign start_ramp = (q.st == LSS_BRAKE_WAIT) && sel_any && brake_done;

    lss_delay_timer #(.W(LSS_W)) u_brake_tmr (
        .clk(clk),
        .rst(rst),
        .tick(q.tick),
        .start(start_brake),
        .abort(!sel_any),
        .load(q.brake_dly),
        .done(brake_done)
    );

    lss_delay_timer #(.W(LSS_W)) u_mon_tmr (
        .clk(clk),
        .rst(rst),
        .tick(q.tick),
        .start(start_mon),
        .abort(!sel_any),
        .load(q.mon_dly),
        .done(mon_done)
    );

    // Held in abort outside the ramp phase so a stale envelope never flags
    lss_ramp_monitor #(.W(LSS_W)) u_ramp (
        .clk(clk),
        .rst(rst),
        .tick(q.tick),
        .start(start_ramp),
        .abort(!sel_any || (q.st != LSS_RAMP_MON && !start_ramp)),
        .speed(load_speed),
        .limit(q.limit),
        .step(q.step),
        .reached(ramp_reached),
        .too_slow(ramp_slow)
    );

    always_comb begin
        next_q = q;
        ev = '0;
        // Millisecond tick divider
        next_q.tick = 1'b0;
        if (q.div >= 32'(TICK_DIV - 1)) begin
            next_q.div = '0;
            next_q.tick = 1'b1;
        end else begin
            next_q.div = q.div + 32'h0000_0001;
        end
        // Sequencer
        unique case (q.st)
            LSS_IDLE: begin
                if (sel_any) next_q.st = q.ramp_sup ? LSS_BRAKE_WAIT : LSS_DELAY;
            end
            LSS_BRAKE_WAIT: begin
                if (brake_done) next_q.st = LSS_RAMP_MON;
            end
            LSS_RAMP_MON: begin
                // ramp at limit, or speed at limit after delay
                if (ramp_reached || load_speed <= q.limit) next_q.st = LSS_MONITOR;
                // too-slow braking caught inside the ramp phase
                ev[EV_TOO_SLOW] = ramp_slow;
            end
            LSS_DELAY: begin
                // monitor only after the separate delay
                if (mon_done) next_q.st = LSS_MONITOR;
            end
            LSS_MONITOR: begin
                ev[EV_OVER_LIMIT] = load_speed > q.limit;
            end
            default: next_q.st = LSS_IDLE; // Unused codes fall back to idle
        endcase
        if (!sel_any) next_q.st = LSS_IDLE;
        // active flag follows the monitoring state
        next_q.active = (next_q.st == LSS_MONITOR);
        ev[EV_ACTIVE] = next_q.active && !q.active;
        // clamp and quick-stop braking while selected
        // a setpoint at or below the clamp passes unchanged
        if (next_q.st != LSS_IDLE && speed_setpoint > clamp_val) begin
            next_q.setpoint = clamp_val;
        end else begin
            next_q.setpoint = speed_setpoint;
        end
        next_q.quick_stop = (next_q.st != LSS_IDLE) && (load_speed > clamp_val);
        next_q.run_en = run_command;
        // Register writes
        if (wr_en) begin
            unique case (paddr)
                ADDR_CTRL: next_q.ramp_sup = pwdata[CTRL_RAMP_SUP];
                ADDR_LIMIT: next_q.limit = pwdata[LSS_W-1:0];
                ADDR_MARGIN: next_q.margin = pwdata[LSS_W-1:0];
                ADDR_BRAKE_DLY: next_q.brake_dly = pwdata[LSS_W-1:0];
                ADDR_MON_DLY: next_q.mon_dly = pwdata[LSS_W-1:0];
                ADDR_STEP: next_q.step = pwdata[LSS_W-1:0];
                ADDR_IRQ_EN: next_q.irq_en = pwdata[EV_N-1:0];
                default: ;
            endcase
        end
        // Sticky events; a set in the clear cycle wins
        next_q.irq_stat = (q.irq_stat & ~clr) | ev;
        // Read data captured in setup, valid through the access phase
        if (rd_en) begin
            unique case (paddr)
                ADDR_CTRL: next_q.prdata = 32'(q.ramp_sup);
                ADDR_LIMIT: next_q.prdata = 32'(q.limit);
                ADDR_MARGIN: next_q.prdata = 32'(q.margin);
                ADDR_BRAKE_DLY: next_q.prdata = 32'(q.brake_dly);
                ADDR_MON_DLY: next_q.prdata = 32'(q.mon_dly);
                ADDR_STEP: next_q.prdata = 32'(q.step);
                ADDR_STATUS: next_q.prdata = 32'({q.st, q.active});
                ADDR_IRQ_STAT: next_q.prdata = 32'(q.irq_stat);
                ADDR_IRQ_EN: next_q.prdata = 32'(q.irq_en);
                default: next_q.prdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{st: LSS_IDLE, ramp_sup: RST_RAMP_SUP, limit: RST_LIMIT,
                margin: RST_MARGIN, brake_dly: RST_BRAKE_DLY, mon_dly: RST_MON_DLY,
                step: RST_STEP, irq_stat: RST_IRQ, irq_en: RST_IRQ, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign prdata = q.prdata;
    assign setpoint_out = q.setpoint;
    assign quick_stop_command = q.quick_stop;
    assign run_enable = q.run_en;
    assign limited_speed_active = q.active;
    assign irq = |(q.irq_stat & q.irq_en);

    // Checks on the one clock, quiet while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_select_leaves_idle: assert property (
        (q.st == LSS_IDLE && sel_any) |=> q.st != LSS_IDLE)
        else $error("selection not taken");
    a_clamp_value: assert property (
        (q.st != LSS_IDLE && sel_any && speed_setpoint > clamp_val) |=> setpoint_out == $past(clamp_val))
        else $error("setpoint not clamped");
    a_quick_stop_on: assert property (
        (q.st != LSS_IDLE && sel_any && load_speed > clamp_val) |=> quick_stop_command)
        else $error("quick stop missing");
    a_mode_choice: assert property (
        (q.st == LSS_IDLE && sel_any) |=> (q.st == LSS_BRAKE_WAIT) == $past(q.ramp_sup))
        else $error("wrong mode path");
    a_ramp_entry: assert property (
        (q.st == LSS_BRAKE_WAIT && sel_any && brake_done) |=> q.st == LSS_RAMP_MON)
        else $error("ramp monitor not entered");
    a_ramp_exit: assert property (
        (q.st == LSS_RAMP_MON && sel_any && (ramp_reached || load_speed <= q.limit))
        |=> q.st == LSS_MONITOR && limited_speed_active)
        else $error("ramp exit missed");
    a_too_slow_flag: assert property (
        (q.st == LSS_RAMP_MON && ramp_slow) |=> q.irq_stat[EV_TOO_SLOW])
        else $error("slow braking not flagged");
    a_delay_mon: assert property (
        (q.st == LSS_DELAY && !mon_done) |=> q.st != LSS_MONITOR)
        else $error("monitoring before delay");
    a_deselect_clear: assert property (
        !sel_any |=> q.st == LSS_IDLE && !limited_speed_active && !quick_stop_command
        && setpoint_out == $past(speed_setpoint))
        else $error("deselect not honoured");
    a_run_passes: assert property (
        !$past(rst) |-> run_enable == $past(run_command))
        else $error("run command restricted");
    a_low_follow: assert property (
        (q.st != LSS_IDLE && sel_any && speed_setpoint <= clamp_val)
        |=> setpoint_out == $past(speed_setpoint))
        else $error("low setpoint altered");
    a_active_state: assert property (
        limited_speed_active == (q.st == LSS_MONITOR))
        else $error("active flag mismatch");
    a_active_event: assert property (
        $rose(limited_speed_active) |-> q.irq_stat[EV_ACTIVE])
        else $error("active event not recorded");
    a_event_sticky: assert property (
        (q.irq_stat[EV_ACTIVE] && !clr[EV_ACTIVE]) |=> q.irq_stat[EV_ACTIVE])
        else $error("active event lost");
    a_mon_entry: assert property (
        (q.st == LSS_DELAY && sel_any && mon_done)
        |=> q.st == LSS_MONITOR && limited_speed_active)
        else $error("monitoring not started after delay");
    a_brake_hold: assert property (
        (q.st == LSS_BRAKE_WAIT && !brake_done) |=> q.st inside {LSS_IDLE, LSS_BRAKE_WAIT})
        else $error("ramp monitor before braking delay");
    a_slow_in_ramp: assert property (
        (q.st != LSS_RAMP_MON && !q.irq_stat[EV_TOO_SLOW]) |=> !q.irq_stat[EV_TOO_SLOW])
        else $error("slow flag outside ramp phase");
    a_low_no_brake: assert property (
        (q.st == LSS_DELAY && sel_any && load_speed <= clamp_val) |=> !quick_stop_command)
        else $error("braking at low speed");

    // Main scenarios for coverage
    c_ramp_path: cover property (q.st == LSS_RAMP_MON ##1 q.st == LSS_MONITOR);
    c_delay_path: cover property (q.st == LSS_DELAY ##1 q.st == LSS_MONITOR);
    c_too_slow: cover property ($rose(q.irq_stat[EV_TOO_SLOW]));
    c_ramp_reached: cover property (q.st == LSS_RAMP_MON && ramp_reached);
    c_deselect: cover property ($fell(limited_speed_active));
endmodule : lss_limited_speed_select

/* lss_pkg.sv */
// Shared constants, register map and state type for the limited-speed selector
package lss_pkg;
    // Speed and delay word width
    localparam int LSS_W = 16;
    // Timing: one delay tick per millisecond at a 50 MHz clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_MARGIN = 8'h08;
    localparam logic [7:0] ADDR_BRAKE_DLY = 8'h0C;
    localparam logic [7:0] ADDR_MON_DLY = 8'h10;
    localparam logic [7:0] ADDR_STEP = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h20;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h24;
    // Field positions
    localparam int CTRL_RAMP_SUP = 0;
    localparam int STAT_ACTIVE = 0;
    localparam int STAT_STATE_LSB = 1;
    localparam int EV_ACTIVE = 0;
    localparam int EV_TOO_SLOW = 1;
    localparam int EV_OVER_LIMIT = 2;
    localparam int EV_N = 3;
    // Reset values
    localparam logic RST_RAMP_SUP = 1'b1;
    localparam logic [LSS_W-1:0] RST_LIMIT = 16'h0400;
    localparam logic [LSS_W-1:0] RST_MARGIN = 16'h0010;
    localparam logic [LSS_W-1:0] RST_BRAKE_DLY = 16'h0064;
    localparam logic [LSS_W-1:0] RST_MON_DLY = 16'h0064;
    localparam logic [LSS_W-1:0] RST_STEP = 16'h0008;
    localparam logic [EV_N-1:0] RST_IRQ = 3'h0;
    // Sequencer states
    typedef enum logic [2:0] {
        LSS_IDLE,
        LSS_BRAKE_WAIT,
        LSS_RAMP_MON,
        LSS_DELAY,
        LSS_MONITOR
    } lss_state_e;
endpackage : lss_pkg

/* lss_ramp_monitor.sv */
// Braking ramp monitor: a falling envelope the load speed must stay under
module lss_ramp_monitor
    import lss_pkg::*;
#(
    parameter int W = LSS_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic [W-1:0] speed,
    input wire logic [W-1:0] limit,
    input wire logic [W-1:0] step,
    output logic reached,
    output logic too_slow
);
    // Elaboration check: the envelope needs room to fall in steps
    if (W < 2) begin : g_bad_width
        $error("lss_ramp_monitor: W too small");
    end

    typedef struct packed {
        logic [W-1:0] ramp;
        logic run;
        logic reached;
        logic too_slow;
    } lss_ramp_s;

    lss_ramp_s q, next_q;
    logic [W:0] floor_sum;

    // Ramp starts at the speed seen at start and falls by step per tick
    always_comb begin
        next_q = q;
        floor_sum = {1'b0, limit} + {1'b0, step};
        if (abort) begin
            next_q = '0;
        end else if (start) begin
            next_q.ramp = speed;
            next_q.run = 1'b1;
            next_q.reached = 1'b0;
            next_q.too_slow = 1'b0;
        end else if (q.run) begin
            if (tick) begin
                // Floor at the limit so the envelope never dips below it
                next_q.ramp = ({1'b0, q.ramp} > floor_sum) ? q.ramp - step : limit;
            end
            next_q.reached = (q.ramp <= limit);
            next_q.too_slow = (speed > q.ramp);
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign reached = q.reached;
    assign too_slow = q.too_slow;
endmodule : lss_ramp_monitor

/* tb.sv */
// Self-checking bench for the limited-speed selector
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lss_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, want_sel, via_bus;
    logic failsafe_input, fieldbus_select, run_enable, qs, active, irq;
    logic run_command = 1'b0;
    logic prev_run = 1'b0;
    logic up = 1'b0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [LSS_W-1:0] load_speed, speed_setpoint, setpoint_out, sp;
    logic [32:0] exp_q[$];
    logic [31:0] rv [11] = '{32'h1, 32'h400, 32'h10, 32'h64, 32'h64, 32'h8, 0, 0, 0, 0, 0};
    int fail_count = 0;
    int tests_run = 0;
    int n;

    lss_limited_speed_select #(.TICK_DIV(4)) uut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .failsafe_input(failsafe_input), .fieldbus_select(fieldbus_select),
        .run_command(run_command), .load_speed(load_speed),
        .speed_setpoint(speed_setpoint), .setpoint_out(setpoint_out),
        .quick_stop_command(qs), .run_enable(run_enable),
        .limited_speed_active(active), .irq(irq));

    lss_ctrl_model partner (.clk(clk), .rst(rst), .want_sel(want_sel), .via_bus(via_bus),
        .failsafe_input(failsafe_input), .fieldbus_select(fieldbus_select));

    task check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; a read notes its expected word and error flag
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back({e, d});
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task sel(input logic on, input logic bus);
        want_sel <= on;
        via_bus <= bus;
        repeat (5) @(posedge clk);
    endtask : sel

    // Bounded wait for the active flag
    task wait_act();
        n = 0;
        while (active !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_act

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Read results pop the oldest note when the access completes
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        if (up) check(run_enable, prev_run);
        up = !rst;
        prev_run = run_command;
        run_command <= 1'($urandom_range(1));
    end

    // Watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        void'($urandom(32'hb7e95405));
        rst = 1'b1;
        {psel, penable, pwrite, want_sel, via_bus} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        load_speed = 16'h0000;
        speed_setpoint = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, then an unmapped word
        for (int i = 0; i < 11; i++) apb(1'b0, 8'(i * 4), rv[i], i == 10);
        apb(1'b1, ADDR_BRAKE_DLY, 32'h6, 1'b0);
        apb(1'b1, ADDR_MON_DLY, 32'h3, 1'b0);
        apb(1'b1, ADDR_IRQ_EN, 32'h1, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0, 1'b0);
        // delay mode from the fieldbus at high speed
        load_speed <= 16'h0800 + 16'($urandom_range(4095));
        sp = 16'h0400 + 16'($urandom_range(16383));
        speed_setpoint <= sp;
        sel(1'b1, 1'b1);
        check(setpoint_out, 16'h03F0);
        check(qs, 1'b1);
        check(active, 1'b0);
        wait_act();
        check(n >= 3 && n <= 20, 1'b1);
        check(irq, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h9, 1'b0);
        apb(1'b1, ADDR_IRQ_CLR, 32'h1, 1'b0);
        check(irq, 1'b0);
        sel(1'b0, 1'b1);
        check(setpoint_out, sp);
        check({qs, active}, 2'b00);
        apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
        load_speed <= 16'h0100;
        speed_setpoint <= 16'h0200;
        sel(1'b1, 1'b0);
        check(setpoint_out, 16'h0200);
        check(qs, 1'b0);
        wait_act();
        check(active, 1'b1);
        sel(1'b0, 1'b0);
        // ramp supervision from the safety input
        apb(1'b1, ADDR_IRQ_CLR, 32'h7, 1'b0);
        apb(1'b1, ADDR_IRQ_EN, 32'h7, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1, 1'b0);
        load_speed <= 16'h0500;
        sp = 16'h0400 + 16'($urandom_range(16383));
        speed_setpoint <= sp;
        sel(1'b1, 1'b0);
        check(setpoint_out, 16'h03F0);
        apb(1'b0, ADDR_STATUS, 32'h2, 1'b0);
        repeat (34) @(posedge clk);
        load_speed <= 16'h0700;
        repeat (3) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h4, 1'b0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h2, 1'b0);
        load_speed <= 16'h0300;
        wait_act();
        check(n < 10, 1'b1);
        apb(1'b0, ADDR_IRQ_STAT, 32'h3, 1'b0);
        load_speed <= 16'h0500;
        repeat (3) @(posedge clk);
        apb(1'b0, ADDR_IRQ_STAT, 32'h7, 1'b0);
        load_speed <= 16'h0300;
        apb(1'b1, ADDR_IRQ_CLR, 32'h7, 1'b0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0, 1'b0);
        check(irq, 1'b0);
        sel(1'b0, 1'b0);
        check({qs, active}, 2'b00);
        check(setpoint_out, sp);
        // envelope reaches the limit while the speed stays just above it
        load_speed <= 16'h0480;
        sel(1'b1, 1'b1);
        wait_act();
        check(active, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h9, 1'b0);
        sel(1'b0, 1'b1);
        check({qs, active}, 2'b00);
        report_and_stop();
    end
endmodule : tb
